// ---- oacl_pkg.sv ----
// constants and types of the oscillator calibration loop
// assumes a 50 MHz system clock and a classic wishbone slave port
// How it works
// - fast loop code 00 internal, 01 crystal
// - slow loop bit: 0 internal, 1 crystal
// - enable bit starts loop, clear stops it
// - enable reads one until loop really stops
// - thirteen bit value: 7 fine, 6 coarse
// - disabled loop: software tunes, oscillator follows
// - enabled loop ignores calibration writes
// - reset loads factory calibration into both parts
// - loop steps only the fine part
// - sixteen bit ratio against 1.024 kHz reference
// - ratio in two bytes, low first, reset zero
package oacl_pkg;
    // ****************************************
    // register indices, byte address is four times these
    // ****************************************
    localparam logic [3:0] IDX_ENABLE = 4'h0;
    localparam logic [3:0] IDX_FINE = 4'h2;
    localparam logic [3:0] IDX_COARSE = 4'h3;
    localparam logic [3:0] IDX_RATIO_LO = 4'h5;
    localparam logic [3:0] IDX_RATIO_HI = 4'h6;
    localparam logic [3:0] IDX_REF_SEL = 4'h8;
    // ****************************************
    // field positions and widths
    // ****************************************
    localparam int FINE_W = 7;
    localparam int COARSE_W = 6;
    localparam int RATIO_W = 16;
    localparam int BIT_ENABLE = 0;
    localparam int BIT_SLOW_REF = 0;
    localparam int POS_FAST_REF = 1;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_RATIO_BYTE = 8'h00;
    localparam logic [1:0] RST_FAST_REF = 2'h0;
    localparam logic RST_SLOW_REF = 1'b0;
    // ****************************************
    // reference codes
    // ****************************************
    localparam logic [1:0] REF_INTERNAL = 2'h0;
    localparam logic [1:0] REF_CRYSTAL = 2'h1;
    // ****************************************
    // counts
    // ****************************************
    localparam int REF_HZ = 32768;
    localparam int CMP_REF_HZ = 1024;
    localparam int REF_DIV = REF_HZ / CMP_REF_HZ;
    localparam logic [4:0] REF_DIV_LAST = 5'(REF_DIV - 1);
    localparam logic [FINE_W-1:0] FINE_MAX = 7'h7F;
    localparam logic [FINE_W-1:0] FINE_MIN = 7'h00;
    // ****************************************
    // loop states
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARM,
        ST_MEASURE,
        ST_STOPPING
    } oacl_state_t;
endpackage

// ---- oacl_ref_if.sv ----
// link between the loop and its reference divider
// assumes both ends sit on the system clock
`timescale 1ns/1ps
`default_nettype none
interface oacl_ref_if;
    logic [1:0] ref_code; // chosen reference code
    logic period_pulse; // one 1.024 kHz period ended
    // ****************************************
    // modports
    // ****************************************
    modport src (input ref_code, output period_pulse);
    modport sink (output ref_code, input period_pulse);
endinterface
`default_nettype wire

// ---- oacl_ref_div.sv ----
// reference picker and divider to 1.024 kHz periods
// assumes reference inputs already synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module oacl_ref_div
    import oacl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ref_int_i,
    input wire logic ref_ext_i,
    oacl_ref_if.src ref_if
);
    // ****************************************
    // reference choice
    // ****************************************
    logic ref_lvl; // chosen reference level
    logic ref_ok; // code is not reserved
    logic ref_prev_reg; // last reference level
    logic [4:0] div_reg; // edges in this period
    logic rise; // reference rising edge
    // reserved codes give no reference at all
    always_comb begin
        case (ref_if.ref_code)
            REF_INTERNAL: begin
                ref_lvl = ref_int_i;
                ref_ok = 1'b1;
            end
            REF_CRYSTAL: begin
                ref_lvl = ref_ext_i;
                ref_ok = 1'b1;
            end
            default: begin
                ref_lvl = 1'b0;
                ref_ok = 1'b0;
            end
        endcase
    end
    assign rise = ref_ok && ref_lvl && !ref_prev_reg;
    // edge history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_prev_reg <= 1'b0;
        end else begin
            ref_prev_reg <= ref_lvl;
        end
    end
    // ****************************************
    // divide by 32 edges
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= 5'h00;
        end else if (rise) begin
            div_reg <= (div_reg == REF_DIV_LAST) ? 5'h00 : div_reg + 5'h01;
        end
    end
    assign ref_if.period_pulse = rise && (div_reg == REF_DIV_LAST);
endmodule
`default_nettype wire

// ---- oacl_top.sv ----
// frequency locked tuner for an internal rc oscillator
// assumes oscillator ticks and references synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module oacl_top
    import oacl_pkg::*;
#(
    parameter bit FAST_LOOP = 1'b1 // 1 fast loop, 0 slow loop
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:2] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // factory values from signature storage
    input wire logic [oacl_pkg::FINE_W-1:0] factory_fine_i,
    input wire logic [oacl_pkg::COARSE_W-1:0] factory_coarse_i,
    // reference clocks, sampled
    input wire logic internal_slow_rc_i,
    input wire logic external_watch_crystal_i,
    // one pulse per counted oscillator cycle
    input wire logic osc_tick_i,
    // tuning to the oscillator
    output logic [oacl_pkg::FINE_W-1:0] tune_fine_part_o,
    output logic [oacl_pkg::COARSE_W-1:0] tune_coarse_part_o,
    output logic [1:0] fast_loop_ref_select_o,
    output logic slow_loop_ref_select_o,
    output logic loop_active_o
);
    // ****************************************
    // declarations
    // ****************************************
    oacl_state_t state_reg; // loop state
    oacl_state_t state_next; // loop state next
    logic ack_reg; // bus answer
    logic [31:0] dat_reg; // read data
    logic wr_en; // write takes effect now
    logic sel_ok; // low byte lane chosen
    logic [7:0] wr_byte; // written byte
    logic [FINE_W-1:0] fine_reg; // fine part
    logic [COARSE_W-1:0] coarse_reg; // coarse part
    logic [7:0] ratio_lo_reg; // ratio bits 7:0
    logic [7:0] ratio_hi_reg; // ratio bits 15:8
    logic [1:0] fast_ref_reg; // fast loop reference
    logic slow_ref_reg; // slow loop reference
    logic [RATIO_W-1:0] count_reg; // ticks this period
    logic [RATIO_W-1:0] ratio; // joined ratio
    logic enable_wr; // write to enable register
    logic enable_val; // written enable bit
    logic period; // reference period ended
    logic active; // loop holds calibration
    // carries the code out and the pulses back
    oacl_ref_if ref_if ();

    // ****************************************
    // register map, byte address four times index
    // ****************************************
    // index 0: loop enable in bit 0
    // reads back one while the loop still runs
    // index 2: fine part in bits 6:0
    // index 3: coarse part in bits 5:0
    // index 5: ratio bits 7:0
    // index 6: ratio bits 15:8
    // index 8: slow reference bit 0
    // index 8: fast reference code in bits 2:1
    // other indices read zero, writes dropped
    // upper bits of every register read zero
    // only byte lane 0 takes part in writes

    // ****************************************
    // helper functions
    // ****************************************
    // the fine part clips at both ends
    // a wrap would throw the oscillator far off
    // saturating step of the fine part
    function automatic logic [FINE_W-1:0] step_fine(
        input logic [FINE_W-1:0] cur,
        input logic up
    );
        logic [FINE_W-1:0] res;
        res = cur;
        if (up && cur != FINE_MAX) begin
            res = cur + 7'h01;
        end else if (!up && cur != FINE_MIN) begin
            res = cur - 7'h01;
        end
        return res;
    endfunction

    // every register is one byte wide
    // low byte padded to a bus word
    function automatic logic [31:0] to_word(input logic [7:0] b);
        return {24'h000000, b};
    endfunction

    // ****************************************
    // reference divider
    // ****************************************
    // the FAST_LOOP parameter picks which field gives the reference code
    assign ref_if.ref_code = FAST_LOOP ? fast_ref_reg : {1'b0, slow_ref_reg};
    oacl_ref_div u_ref_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ref_int_i(internal_slow_rc_i),
        .ref_ext_i(external_watch_crystal_i),
        .ref_if(ref_if)
    );
    assign period = ref_if.period_pulse;
    // period pulses only for a valid code
    // reserved codes starve the loop of periods

    // ****************************************
    // wishbone slave
    // ****************************************
    // request taken on the edge with ack low
    // ack rises for exactly one cycle after it
    // master must drop cyc and stb after ack
    // holding them would start a second cycle
    // unmapped indices are answered as well
    // answer one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= cyc_i && stb_i && !ack_reg;
        end
    end
    assign ack_o = ack_reg;

    // write data and address must still stand here
    // lanes 3:1 are ignored
    // writes land on the edge that sees ack
    assign sel_ok = sel_i[0];
    assign wr_en = cyc_i && stb_i && we_i && ack_reg && sel_ok;
    assign wr_byte = dat_i[7:0];
    assign enable_wr = wr_en && (adr_i == IDX_ENABLE);
    assign enable_val = wr_byte[BIT_ENABLE];

    // read data is captured when the request is taken
    // it stays until the next request is taken
    // read data loads with the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h00000000;
        end else if (cyc_i && stb_i && !ack_reg) begin
            case (adr_i)
                IDX_ENABLE: begin
                    // stays one until stopped
                    dat_reg <= to_word({7'h00, active});
                end
                IDX_FINE: begin
                    dat_reg <= to_word({1'b0, fine_reg});
                end
                IDX_COARSE: begin
                    dat_reg <= to_word({2'h0, coarse_reg});
                end
                IDX_RATIO_LO: begin
                    dat_reg <= to_word(ratio_lo_reg);
                end
                IDX_RATIO_HI: begin
                    dat_reg <= to_word(ratio_hi_reg);
                end
                IDX_REF_SEL: begin
                    // reserved bits read zero
                    dat_reg <= to_word({5'h00, fast_ref_reg, slow_ref_reg});
                end
                default: begin
                    // unmapped reads zero
                    dat_reg <= 32'h00000000;
                end
            endcase
        end
    end
    assign dat_o = dat_reg;

    // ****************************************
    // loop state machine
    // ****************************************
    // idle: oscillator follows the held value
    // arm: waits for the first period to end
    // the first count would be partial, so skip it
    // measure: one step per later period end
    // stopping: enable still reads one
    // the last period must finish before idle
    // so the reference has to keep running
    // turning it off early leaves this state stuck
    // disable while arming stops at once
    // re-enable while stopping resumes measuring unless a period ends that cycle
    // loop stops at a period boundary, except from arm
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (enable_wr && enable_val) begin
                    state_next = ST_ARM;
                end
            end
            ST_ARM: begin
                // no measurement yet, stop at once
                if (enable_wr && !enable_val) begin
                    state_next = ST_IDLE;
                end else if (period) begin
                    state_next = ST_MEASURE;
                end
            end
            ST_MEASURE: begin
                if (enable_wr && !enable_val) begin
                    state_next = ST_STOPPING;
                end
            end
            ST_STOPPING: begin
                // needs the reference kept running
                if (period) begin
                    state_next = ST_IDLE;
                end else if (enable_wr && enable_val) begin
                    state_next = ST_MEASURE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // one flop set holds the loop phase
    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end
    assign active = (state_reg != ST_IDLE);
    assign loop_active_o = active;

    // ****************************************
    // oscillator tick counter
    // ****************************************
    // counts oscillator ticks between pulses
    // the pulse cycle itself starts a new count
    // saturation keeps a fast oscillator from wrapping
    // a wrapped count would step the wrong way
    // idle holds the count at zero
    // restart each period, saturate at top
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= '0;
        end else if (period || state_reg == ST_IDLE) begin
            count_reg <= '0;
        end else if (osc_tick_i && count_reg != '1) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // ****************************************
    // calibration registers
    // ****************************************
    // fine part: software while idle, loop while active
    // coarse part: software while idle only
    // reset reloads both from the factory inputs
    // fine and coarse writes while active are acked but dropped
    assign ratio = {ratio_hi_reg, ratio_lo_reg};

    // fine part: factory, software or loop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fine_reg <= factory_fine_i;
        end else if (!active) begin
            if (wr_en && adr_i == IDX_FINE) begin
                fine_reg <= wr_byte[FINE_W-1:0];
            end
        end else if (period && state_reg != ST_ARM) begin
            // writes ignored here, loop steps
            if (count_reg < ratio) begin
                fine_reg <= step_fine(fine_reg, 1'b1);
            end else if (count_reg > ratio) begin
                fine_reg <= step_fine(fine_reg, 1'b0);
            end
        end
    end

    // only software may change the range
    // the loop has no path into this register
    // coarse part: never touched by the loop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            coarse_reg <= factory_coarse_i;
        end else if (!active && wr_en && adr_i == IDX_COARSE) begin
            coarse_reg <= wr_byte[COARSE_W-1:0];
        end
    end

    // the two bytes are written one at a time
    // the loop may compare against a half-written ratio
    // one wrong step at most, then it recovers
    // ratio bytes, low byte at lower index
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ratio_lo_reg <= RST_RATIO_BYTE;
            ratio_hi_reg <= RST_RATIO_BYTE;
        end else if (wr_en) begin
            if (adr_i == IDX_RATIO_LO) begin
                ratio_lo_reg <= wr_byte;
            end
            if (adr_i == IDX_RATIO_HI) begin
                ratio_hi_reg <= wr_byte;
            end
        end
    end

    // both fields share one register
    // changing the code mid-run can add one stray edge
    // software should change it with the loop idle
    // reference select fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_ref_reg <= RST_FAST_REF;
            slow_ref_reg <= RST_SLOW_REF;
        end else if (wr_en && adr_i == IDX_REF_SEL) begin
            fast_ref_reg <= wr_byte[POS_FAST_REF +: 2];
            slow_ref_reg <= wr_byte[BIT_SLOW_REF];
        end
    end

    // ****************************************
    // outputs to the oscillator
    // ****************************************
    // tuning values go straight from registers
    // no glitches reach the oscillator this way
    // reference selects feed the oscillator block
    // loop_active_o mirrors the readable enable bit
    // oscillator follows the held value
    assign tune_fine_part_o = fine_reg;
    assign tune_coarse_part_o = coarse_reg;
    assign fast_loop_ref_select_o = fast_ref_reg;
    assign slow_loop_ref_select_o = slow_ref_reg;
endmodule
`default_nettype wire

// ---- oacl_properties.sv ----
// port checks for the oscillator calibration loop
// assumes a bind onto oacl_top, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module oacl_props
    import oacl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [5:2] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic [oacl_pkg::FINE_W-1:0] factory_fine_i,
    input wire logic [oacl_pkg::COARSE_W-1:0] factory_coarse_i,
    input wire logic [oacl_pkg::FINE_W-1:0] tune_fine_part_o,
    input wire logic [oacl_pkg::COARSE_W-1:0] tune_coarse_part_o,
    input wire logic [1:0] fast_loop_ref_select_o,
    input wire logic loop_active_o
);
    // ****************************************
    // helpers
    // ****************************************
    wire [6:0] wr_fine = dat_i[6:0]; // fine field of write data
    wire [1:0] wr_ref = dat_i[2:1]; // fast code of write data
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // write landing at this edge
    sequence s_wr(logic [3:0] idx);
        ack_o && we_i && sel_i[0] && adr_i == idx;
    endsequence
    // read answered at this edge
    sequence s_rd(logic [3:0] idx);
        ack_o && !we_i && adr_i == idx;
    endsequence
    // ****************************************
    // assertions
    // ****************************************
    a_reset_factory: assert property (disable iff (1'b0) rst_i |=>
        tune_fine_part_o == $past(factory_fine_i) && tune_coarse_part_o == $past(factory_coarse_i))
        else $error("factory values not loaded");
    a_reset_idle: assert property (disable iff (1'b0) rst_i |=> !loop_active_o && fast_loop_ref_select_o == 2'h0)
        else $error("loop or reference not cleared");
    a_manual_tune: assert property (s_wr(IDX_FINE) ##0 !loop_active_o |=> tune_fine_part_o == $past(wr_fine))
        else $error("manual fine write lost");
    a_coarse_held: assert property (loop_active_o |=> $stable(tune_coarse_part_o))
        else $error("coarse moved while loop active");
    a_fine_step: assert property (loop_active_o |=>
        7'(tune_fine_part_o - $past(tune_fine_part_o)) inside {7'h00, 7'h01, 7'h7F})
        else $error("fine moved by more than one");
    a_idle_hold: assert property (!loop_active_o && !(ack_o && we_i) |=> $stable(tune_fine_part_o))
        else $error("fine moved while idle");
    a_enable_read: assert property (s_rd(IDX_ENABLE) |-> dat_o == {31'h0, $past(loop_active_o)})
        else $error("enable read differs from loop state");
    a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("reserved read bits not zero");
    a_ref_code: assert property (s_wr(IDX_REF_SEL) |=> fast_loop_ref_select_o == $past(wr_ref))
        else $error("reference code not taken");
    a_enable_start: assert property (s_wr(IDX_ENABLE) ##0 (dat_i[0] && !loop_active_o) |=> ##[0:1] loop_active_o)
        else $error("loop did not start");
endmodule
bind oacl_top oacl_props u_props (.clk_i(clk_i), .rst_i(rst_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .factory_fine_i(factory_fine_i),
    .factory_coarse_i(factory_coarse_i), .tune_fine_part_o(tune_fine_part_o),
    .tune_coarse_part_o(tune_coarse_part_o), .fast_loop_ref_select_o(fast_loop_ref_select_o),
    .loop_active_o(loop_active_o));
`default_nettype wire

// ---- oacl_osc_model.sv ----
// stand-in for both references and the tuned oscillator
// assumes all levels are made on the system clock
`timescale 1ns/1ps
`default_nettype none
module oacl_osc_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_int_i,
    input wire logic run_ext_i,
    output logic ref_int_o,
    output logic ref_ext_o,
    output logic osc_tick_o
);
    logic [1:0] ph_reg; // divider phase
    // references toggle every second cycle, low while stopped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_reg <= 2'h0;
            ref_int_o <= 1'b0;
            ref_ext_o <= 1'b0;
        end else begin
            ph_reg <= ph_reg + 2'h1;
            if (ph_reg[0]) begin
                ref_int_o <= run_int_i & ~ref_int_o;
                ref_ext_o <= run_ext_i & ~ref_ext_o;
            end
        end
    end
    // oscillator cycle every fourth system cycle
    assign osc_tick_o = (ph_reg == 2'h3);
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// register level bench for the calibration loop
// assumes oacl_top beside the oscillator model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import oacl_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [5:2] adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [3:0] sel_i = 4'h1;
    logic [3:0] wsel = 4'h1; // lanes for the next request
    logic [31:0] dat_o, rd;
    logic ack_o, ref_int, ref_ext, tick, slow_sel, active;
    logic run_int = 1'b0;
    logic run_ext = 1'b0;
    logic [6:0] fine;
    logic [5:0] coarse;
    logic [1:0] fast_sel;
    int error_cnt = 0;
    int check_count = 0;
    always #10 clk_i = ~clk_i;
    oacl_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .factory_fine_i(7'h35),
        .factory_coarse_i(6'h2A), .internal_slow_rc_i(ref_int), .external_watch_crystal_i(ref_ext),
        .osc_tick_i(tick), .tune_fine_part_o(fine), .tune_coarse_part_o(coarse),
        .fast_loop_ref_select_o(fast_sel), .slow_loop_ref_select_o(slow_sel), .loop_active_o(active));
    oacl_osc_model u_osc (.clk_i(clk_i), .rst_i(rst_i), .run_int_i(run_int), .run_ext_i(run_ext),
        .ref_int_o(ref_int), .ref_ext_o(ref_ext), .osc_tick_o(tick));
    // verdict and end of run
    task close_out;
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    // one classic cycle, data taken at the ack edge
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= wsel;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        if (ack_o !== 1'b1) begin
            error_cnt++;
            close_out();
        end
        #1;
    endtask
    task rdc(input logic [3:0] a, input logic [31:0] exp, input string name);
        wb(1'b0, a, 32'h0);
        check(name, exp, rd);
    endtask
    // wait for the loop to walk fine to a target
    task wait_fine(input logic [6:0] t, input logic up);
        int n;
        n = 0;
        while ((up ? fine < t : fine > t) && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 3000) begin
            error_cnt++;
            close_out();
        end
    endtask
    initial begin
        int n;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(IDX_FINE, 32'h35, "fine reset");
        rdc(IDX_COARSE, 32'h2A, "coarse reset");
        rdc(IDX_RATIO_LO, 32'h0, "ratio low reset");
        rdc(IDX_RATIO_HI, 32'h0, "ratio high reset");
        rdc(IDX_ENABLE, 32'h0, "enable reset");
        rdc(IDX_REF_SEL, 32'h0, "ref reset");
        rdc(4'h1, 32'h0, "unmapped");
        wb(1'b1, IDX_FINE, 32'hFF);
        rdc(IDX_FINE, 32'h7F, "fine width");
        wsel = 4'h0;
        wb(1'b1, IDX_FINE, 32'h11);
        wsel = 4'h1;
        rdc(IDX_FINE, 32'h7F, "fine no lane");
        wb(1'b1, IDX_COARSE, 32'hFF);
        rdc(IDX_COARSE, 32'h3F, "coarse width");
        check("coarse out", 32'h3F, 32'(coarse));
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, IDX_REF_SEL, 32'(c * 3));
            check("fast ref", 32'(c * 3 / 2 % 4), 32'(fast_sel));
            check("slow ref", 32'(c % 2), 32'(slow_sel));
        end
        wb(1'b1, IDX_REF_SEL, 32'h0);
        wb(1'b1, IDX_FINE, 32'h40);
        wb(1'b1, IDX_RATIO_LO, 32'h12);
        wb(1'b1, IDX_RATIO_HI, 32'h7A);
        rdc(IDX_RATIO_HI, 32'h7A, "ratio high");
        rdc(IDX_RATIO_LO, 32'h12, "ratio low");
        run_int <= 1'b1;
        repeat (300) @(posedge clk_i);
        wb(1'b1, IDX_ENABLE, 32'h1);
        rdc(IDX_ENABLE, 32'h1, "enable on");
        check("active on", 32'h1, 32'(active));
        wb(1'b1, IDX_COARSE, 32'h05);
        wb(1'b1, IDX_FINE, 32'h05);
        rdc(IDX_COARSE, 32'h3F, "coarse locked");
        wait_fine(7'h43, 1'b1);
        check("coarse kept", 32'h3F, 32'(coarse));
        run_ext <= 1'b1;
        repeat (300) @(posedge clk_i);
        wb(1'b1, IDX_REF_SEL, 32'h2);
        wb(1'b1, IDX_RATIO_HI, 32'h0);
        wb(1'b1, IDX_RATIO_LO, 32'h1);
        run_int <= 1'b0;
        wait_fine(7'h40, 1'b0);
        wb(1'b1, IDX_ENABLE, 32'h0);
        rdc(IDX_ENABLE, 32'h1, "enable stopping");
        check("active stop", 32'h1, 32'(active));
        for (n = 0; n < 100 && rd[0] !== 1'b0; n++)
            wb(1'b0, IDX_ENABLE, 32'h0);
        check("enable off", 32'h0, rd);
        check("active off", 32'h0, 32'(active));
        run_ext <= 1'b0;
        wb(1'b1, IDX_FINE, 32'h22);
        check("fine out", 32'h22, 32'(fine));
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(IDX_FINE, 32'h35, "fine reload");
        rdc(IDX_RATIO_LO, 32'h0, "ratio reload");
        check("active reload", 32'h0, 32'(active));
        close_out();
    end
endmodule
`default_nettype wire
